// ### verilog/bic_top.sv
// Idle cycle insertion and external bus release control, with its two control registers and a status register.
// Assumes the bus controller offers one cycle at a time with valid and waits for start.
// Assumes the bus request pin comes from outside the clock domain; the acknowledge pin is driven by this block.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module bic_top (
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Register port.
  input  wire logic [3:0]          reg_addr_i,
  input  wire logic [15:0]         reg_wdata_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  output logic      [15:0]         reg_rdata_o,
  // Next external cycle from the bus controller.
  input  wire logic                cyc_valid_i,
  input  wire bic_pkg::bic_cycle_t cyc_i,
  output logic                     cyc_start_o,
  output logic                     idle_o,
  // Bus release pins and internal demand.
  input  wire logic                external_request_in_n_i,
  input  wire logic                int_ext_access_i,
  output logic                     bus_released_o,
  output logic                     release_ack_n_o,
  output logic                     internal_request_out_n_o,
  output logic                     release_pins_used_o,
  output logic                     request_pin_used_o
);

  logic [15:0]         idle_ctl_q;
  logic [15:0]         bus_ctl1_q;
  bic_pkg::bic_cycle_t last_q;
  logic                last_vld_q;
  bic_pkg::bic_state_t state_q;
  logic [2:0]          cnt_q;
  logic [2:0]          need_cycles;
  logic [1:0]          req_sync_q;
  logic                released_q;
  logic                use_b;
  logic                cond_any;
  logic                cond_ab;
  logic                cond_a_only;
  logic                rel_grab;

  // Register writes; reserved bits of the bus control register stay zero.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      idle_ctl_q <= bic_pkg::BIC_IDLE_CTL_RST;
      bus_ctl1_q <= bic_pkg::BIC_BUS_CTL1_RST;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == bic_pkg::BIC_OFF_IDLE_CTL)
        idle_ctl_q <= reg_wdata_i;
      else if (reg_addr_i == bic_pkg::BIC_OFF_BUS_CTL1)
        bus_ctl1_q <= reg_wdata_i & bic_pkg::BIC_BUS_CTL1_WMASK;
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      reg_rdata_o <= 16'h0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        bic_pkg::BIC_OFF_IDLE_CTL: reg_rdata_o <= idle_ctl_q;
        bic_pkg::BIC_OFF_BUS_CTL1: reg_rdata_o <= bus_ctl1_q;
        bic_pkg::BIC_OFF_STATUS:   reg_rdata_o <= {12'h000, state_q, released_q, idle_o};
        default:                   reg_rdata_o <= 16'h0000;
      endcase
    end
    else
      reg_rdata_o <= 16'h0000;
  end

  // Classify the pending cycle against the last one run.
  // Transfer-engine write takes precedence, since it only ever uses count A.
  always_comb
  begin
    cond_a_only = 1'b0;
    cond_ab     = 1'b0;
    if (last_vld_q && cyc_valid_i)
    begin
      if (last_q.is_xfer && last_q.is_write)
        cond_a_only = idle_ctl_q[bic_pkg::BIC_POS_EN_XFER];
      else if (last_q.is_write && !cyc_i.is_write)
        cond_a_only = idle_ctl_q[bic_pkg::BIC_POS_EN_WR_RD];
      else if (!last_q.is_write && cyc_i.is_write)
        cond_ab = idle_ctl_q[bic_pkg::BIC_POS_EN_RD_WR];
      else if (!last_q.is_write && (last_q.area != cyc_i.area))
        cond_ab = idle_ctl_q[bic_pkg::BIC_POS_EN_AREA];
    end
    cond_any = cond_a_only | cond_ab;
    // Count B only reachable through the area-change and read-then-write paths.
    use_b = cond_ab & idle_ctl_q[last_q.area];
  end

  // Shared decoder, count A always available as a fallback.
  bic_count_decode u_decode (
    .count_a_i (idle_ctl_q[bic_pkg::BIC_POS_CNT_A +: 2]),
    .count_b_i (idle_ctl_q[bic_pkg::BIC_POS_CNT_B +: 2]),
    .use_b_i   (use_b),
    .cycles_o  (need_cycles)
  );

  // A pending release wins over a new cycle, so no grant can land on a released bus.
  assign rel_grab = bus_ctl1_q[bic_pkg::BIC_POS_REL_EN] & ~req_sync_q[1];

  // Sequencer: count idle cycles, then grant the cycle for one clock.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q     <= bic_pkg::BIC_ST_IDLE;
      cnt_q       <= 3'h0;
      cyc_start_o <= 1'b0;
      idle_o      <= 1'b0;
    end
    else
    begin
      cyc_start_o <= 1'b0;
      case (state_q)
        bic_pkg::BIC_ST_IDLE:
        begin
          if (cyc_valid_i && !released_q && !rel_grab)
          begin
            if (cond_any && (need_cycles != 3'h0))
            begin
              state_q <= bic_pkg::BIC_ST_COUNT;
              cnt_q   <= need_cycles - 3'h1;
              idle_o  <= 1'b1;
            end
            else
            begin
              state_q     <= bic_pkg::BIC_ST_GO;
              cyc_start_o <= 1'b1;
            end
          end
        end
        bic_pkg::BIC_ST_COUNT:
        begin
          if (cnt_q == 3'h0)
          begin
            state_q     <= bic_pkg::BIC_ST_GO;
            idle_o      <= 1'b0;
            cyc_start_o <= 1'b1;
          end
          else
            cnt_q <= cnt_q - 3'h1;
        end
        bic_pkg::BIC_ST_GO:
          state_q <= bic_pkg::BIC_ST_IDLE;
        default:
          state_q <= bic_pkg::BIC_ST_IDLE;
      endcase
    end
  end

  // Remember the cycle just granted for the next comparison.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      last_q     <= '0;
      last_vld_q <= 1'b0;
    end
    else if (cyc_start_o)
    begin
      last_q     <= cyc_i;
      last_vld_q <= 1'b1;
    end
    else if (released_q)
      last_vld_q <= 1'b0;
  end

  // Two-flop synchroniser for the external request pin.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      req_sync_q <= 2'b11;
    else
      req_sync_q <= {req_sync_q[0], external_request_in_n_i};
  end

  // Release only between cycles and only while enabled.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      released_q <= 1'b0;
    else if (!bus_ctl1_q[bic_pkg::BIC_POS_REL_EN])
      released_q <= 1'b0;
    else if (rel_grab && state_q == bic_pkg::BIC_ST_IDLE && !cyc_start_o)
      released_q <= 1'b1;
    else if (req_sync_q[1])
      released_q <= 1'b0;
  end

  // Pin outputs, all registered.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_released_o           <= 1'b0;
      release_ack_n_o          <= 1'b1;
      internal_request_out_n_o <= 1'b1;
      release_pins_used_o      <= 1'b0;
      request_pin_used_o       <= 1'b0;
    end
    else
    begin
      bus_released_o      <= released_q;
      release_ack_n_o     <= !released_q;
      release_pins_used_o <= bus_ctl1_q[bic_pkg::BIC_POS_REL_EN];
      request_pin_used_o  <= bus_ctl1_q[bic_pkg::BIC_POS_REL_EN] &
                             bus_ctl1_q[bic_pkg::BIC_POS_REQO_EN];
      internal_request_out_n_o <= !(bus_ctl1_q[bic_pkg::BIC_POS_REQO_EN] && released_q &&
                                    (int_ext_access_i || cyc_valid_i));
    end
  end

endmodule

// ### verilog/bic_pkg.sv
// Package for the bus idle insertion and release control block.
// Assumes a 16-bit register port with one-cycle strobes and registered read data.
package bic_pkg;

  // Register offsets on the plain register port (word index).
  localparam logic [3:0] BIC_OFF_IDLE_CTL = 4'h0;
  localparam logic [3:0] BIC_OFF_BUS_CTL1 = 4'h1;
  localparam logic [3:0] BIC_OFF_STATUS   = 4'h2;

  // Values after reset.
  localparam logic [15:0] BIC_IDLE_CTL_RST = 16'hff00;
  localparam logic [15:0] BIC_BUS_CTL1_RST = 16'h0000;

  // Field positions in the idle control register.
  localparam int BIC_POS_EN_XFER  = 15;
  localparam int BIC_POS_EN_WR_RD = 14;
  localparam int BIC_POS_EN_AREA  = 13;
  localparam int BIC_POS_EN_RD_WR = 12;
  localparam int BIC_POS_CNT_B    = 10;
  localparam int BIC_POS_CNT_A    = 8;

  // Field positions in the first bus control register.
  localparam int BIC_POS_REL_EN   = 15;
  localparam int BIC_POS_REQO_EN  = 14;
  localparam int BIC_POS_WBUF_EN  = 9;
  localparam int BIC_POS_WAIT_EN  = 8;
  localparam int BIC_POS_ACK_EDGE = 7;

  // Writable bits of the first bus control register; the rest read as zero.
  localparam logic [15:0] BIC_BUS_CTL1_WMASK = 16'hc380;

  // Description of one external bus cycle offered to the idle logic.
  typedef struct packed {
    logic       is_write;
    logic       is_xfer;
    logic [2:0] area;
  } bic_cycle_t;

  // Sequencer states, Gray coded along idle, count, go.
  typedef enum logic [1:0] {
    BIC_ST_IDLE  = 2'b00,
    BIC_ST_COUNT = 2'b01,
    BIC_ST_GO    = 2'b11
  } bic_state_t;

endpackage

// ### verilog/bic_count_decode.sv
// Decodes the two idle count fields into a number of idle cycles.
// Assumes the selection between counts is made by the caller.
`timescale 1ns/1ps
module bic_count_decode (
  // Count fields.
  input  wire logic [1:0] count_a_i,
  input  wire logic [1:0] count_b_i,
  input  wire logic       use_b_i,
  // Decoded number of idle cycles.
  output logic      [2:0] cycles_o
);

  // Count A always gives one more than its code; count B gives none for code zero.
  always_comb
  begin
    if (use_b_i)
    begin
      case (count_b_i)
        2'h0:    cycles_o = 3'h0;
        2'h1:    cycles_o = 3'h2;
        2'h2:    cycles_o = 3'h3;
        default: cycles_o = 3'h4;
      endcase
    end
    else
    begin
      cycles_o = {1'b0, count_a_i} + 3'h1;
    end
  end

endmodule

// ### test/bic_top_monitor.sv
// Port checker for the idle insertion and bus release block.
// Assumes it is bound to bic_top and sees only its ports.
`timescale 1ns/1ps
module bic_top_monitor (
  // Clock, reset and demand.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic int_ext_access_i,
  // Watched outputs.
  input wire logic cyc_start_o,
  input wire logic idle_o,
  input wire logic bus_released_o,
  input wire logic release_ack_n_o,
  input wire logic internal_request_out_n_o,
  input wire logic release_pins_used_o,
  input wire logic request_pin_used_o
);
  // One clock domain, so one default clocking and reset for every check.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_idle_then_start: assert property ($fell(idle_o) |-> cyc_start_o)
    else $error("idle ended without a grant");
  a_idle_at_most: assert property (idle_o [*4] |=> !idle_o)
    else $error("more than four idle cycles");
  a_start_one_cycle: assert property (cyc_start_o |-> !idle_o ##1 !cyc_start_o)
    else $error("grant overlaps idle or lasts too long");
  a_release_gated: assert property (!release_pins_used_o [*3] |-> !bus_released_o)
    else $error("bus released while release disabled");
  a_ack_tracks: assert property (bus_released_o |-> !release_ack_n_o)
    else $error("acknowledge missing while released");
  a_no_grant_out: assert property (bus_released_o |-> !cyc_start_o && !idle_o)
    else $error("bus cycle while released");
  a_reqo_raised: assert property
    ((bus_released_o && request_pin_used_o && int_ext_access_i) [*3]
      |-> !internal_request_out_n_o)
    else $error("request out missing");
  a_reqo_quiet: assert property
    ((!request_pin_used_o || !bus_released_o) [*3] |-> internal_request_out_n_o)
    else $error("request out without cause");
  a_pin_pair: assert property (request_pin_used_o |-> release_pins_used_o)
    else $error("request pin used without release");
endmodule

bind bic_top bic_top_monitor u_bic_top_monitor (.clk_i, .rst_i, .int_ext_access_i,
  .cyc_start_o, .idle_o, .bus_released_o, .release_ack_n_o, .internal_request_out_n_o,
  .release_pins_used_o, .request_pin_used_o);

// ### test/bic_ext_master.sv
// External bus master model that asks for the bus on the request pin.
// Assumes the acknowledge pin of the block and a bench command to want it.
`timescale 1ns/1ps
module bic_ext_master (
  // Clock, reset and command.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       want_i,
  input  wire logic [3:0] hold_i,
  // Pins.
  input  wire logic       ack_n_i,
  output logic            request_n_o
);
  logic [3:0] used_q;

  // Keeps the bus hold_i cycles once granted; hold sets prompt or slow hand-back.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i || !want_i)
    begin
      used_q      <= 4'h0;
      request_n_o <= 1'b1;
    end
    else if (used_q == hold_i)
      request_n_o <= 1'b1;
    else
    begin
      request_n_o <= 1'b0;
      used_q      <= used_q + {3'h0, !ack_n_i};
    end
  end
endmodule

// ### test/tb.sv
// Self-checking bench for bic_top with an external master model.
// Assumes the 125 MHz clock and the hand-over timing of the block.
`timescale 1ns/1ps
module tb;
  logic                clk, rst, wr, rd, valid, int_acc, want;
  logic [3:0]          addr, hold;
  logic [15:0]         wdata, rdata;
  bic_pkg::bic_cycle_t cyc;
  logic                start, idle, rel, ack_n, reqo_n, rel_used, req_used, req_n;
  int                  miscompares, num_checks, cycles, k;
  int                  bcnt[4] = '{0, 2, 3, 4};

  bic_top u_bic_top (.clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .cyc_valid_i(valid), .cyc_i(cyc),
    .cyc_start_o(start), .idle_o(idle), .external_request_in_n_i(req_n),
    .int_ext_access_i(int_acc), .bus_released_o(rel), .release_ack_n_o(ack_n),
    .internal_request_out_n_o(reqo_n), .release_pins_used_o(rel_used),
    .request_pin_used_o(req_used));
  bic_ext_master u_bic_ext_master (.clk_i(clk), .rst_i(rst), .want_i(want), .hold_i(hold),
    .ack_n_i(ack_n), .request_n_o(req_n));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask

  // Grant comes n edges after the taking edge; idle must show for exactly n samples.
  // A grant that never comes is always a mismatch; n below zero skips the counts.
  task automatic run(input logic w, input logic x, input logic [2:0] a, input int n);
    int j;
    j = 0;
    k = 0;
    @(posedge clk);
    valid <= 1'b1;
    cyc <= '{w, x, a};
    do
    begin
      @(posedge clk);
      #1 k++;
      j += int'(idle === 1'b1);
    end while (start !== 1'b1 && k < 40);
    chk("grant", 16'h1, 16'(start));
    @(posedge clk);
    valid <= 1'b0;
    if (n >= 0)
    begin
      chk("grant wait", 16'(n + 1), 16'(k));
      chk("idle cycles", 16'(n), 16'(j));
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Free-running 8 ns clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A hang costs a mismatch; the run needs well under a thousand cycles.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      miscompares++;
      complete_run;
    end
  end

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    {wr, rd, valid, int_acc, want} = '0;
    addr = '0;
    wdata = '0;
    hold = 4'h3;
    cyc = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(4'h0, 16'hff00);
    rd_chk(4'h3, 16'h0000);
    run(0, 0, 0, -1);
    run(1, 0, 0, 4);
    run(0, 0, 0, 4);
    run(0, 0, 1, 4);
    wr_reg(4'h0, 16'hf402);
    run(0, 0, 2, 2);
    run(1, 0, 2, 1);
    run(1, 1, 1, 0);
    run(0, 0, 1, 1);
    run(1, 0, 1, 2);
    run(0, 0, 1, 1);
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(4'h0, 16'hf002 | 16'(c << 10));
      run(1, 0, 1, bcnt[c]);
      run(0, 0, 1, 1);
    end
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(4'h0, 16'hf000 | 16'(c << 8));
      run(1, 0, 0, c + 1);
      run(0, 0, 1, c + 1);
    end
    wr_reg(4'h0, 16'h0f00);
    run(1, 0, 1, 0);
    run(0, 0, 1, 0);
    run(0, 0, 2, 0);
    run(1, 1, 2, 0);
    run(0, 0, 2, 0);
    want <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk("released", 16'h0, 16'(rel));
    chk("pins used", 16'h0, 16'(rel_used));
    @(posedge clk);
    want <= 1'b0;
    // Let the dropped request pass the synchroniser before release is enabled.
    repeat (3) @(posedge clk);
    wr_reg(4'h1, 16'hffff);
    rd_chk(4'h1, 16'hc380);
    wr_reg(4'h1, 16'hc000);
    @(posedge clk);
    want <= 1'b1;
    hold <= 4'h9;
    k = 0;
    do
    begin
      @(posedge clk);
      #1 k++;
    end while (rel !== 1'b1 && k < 20);
    chk("released", 16'h1, 16'(rel));
    chk("ack", 16'h0, 16'(ack_n));
    chk("req pin used", 16'h1, 16'(req_used));
    rd_chk(4'h2, 16'h0002);
    @(posedge clk);
    int_acc <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("request out", 16'h0, 16'(reqo_n));
    @(posedge clk);
    int_acc <= 1'b0;
    run(0, 0, 3, -1);
    #1 chk("released", 16'h0, 16'(rel));
    complete_run;
  end
endmodule
